// ---- osc_pkg.sv ----
package osc_pkg;

    localparam int              ADDR_W          = 9;
    localparam int              DATA_W          = 8;
    localparam int              NUM_DCLK        = 7;

    localparam logic [8:0]      ADDR_PULSE_CNT  = 9'h13E;
    localparam logic [8:0]      ADDR_STEP_CNT   = 9'h142;
    localparam logic [8:0]      ADDR_SYNC_CTRL  = 9'h143;
    localparam logic [8:0]      ADDR_EXCL_MASK  = 9'h144;

    localparam logic [7:0]      SYNC_CTRL_RST   = 8'h01;
    localparam logic [7:0]      EXCL_MASK_RST   = 8'h00;
    localparam logic [7:0]      STEP_CNT_RST    = 8'h00;

    localparam int              BIT_REF_CLEAR   = 7;
    localparam int              BIT_EDGE_SEL    = 6;
    localparam int              BIT_INVERT      = 5;
    localparam int              BIT_SYNC_EN     = 4;
    localparam int              BIT_HOLD_LOOP2  = 3;
    localparam int              BIT_HOLD_LOOP1  = 2;
    localparam int              MODE_MSB        = 1;
    localparam int              MODE_LSB        = 0;
    localparam int              BIT_REF_EXCL    = 7;

    typedef enum logic [1:0] {
        OSC_MODE_OFF      = 2'b00,
        OSC_MODE_DIRECT   = 2'b01,
        OSC_MODE_PULSE_IN = 2'b10,
        OSC_MODE_PULSE_SW = 2'b11
    } osc_mode_e;

    // Least hold time of an edge-triggered event, rounded up to whole cycles.
    localparam int              CLK_PERIOD_NS   = 20;
    localparam int              ONESHOT_NS      = 100;
    localparam int              ONESHOT_CYCLES  = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int              ONESHOT_W       = 4;
    localparam logic [3:0]      ONESHOT_LOAD    = 4'(ONESHOT_CYCLES - 1);
    localparam logic [3:0]      ONESHOT_ZERO    = 4'h0;
    localparam logic [3:0]      ONESHOT_ONE     = 4'h1;

endpackage : osc_pkg

// ---- osc_sync_event_control.sv ----
// How it works
// - Level mode holds outputs while input asserted.
// - Edge mode syncs on rise, fixed minimum hold.
// - Invert bit flips the sensed pin level.
// - Enable bit low blocks sync and pulser triggers; step writes in source three still start the dyn delay.
// - Loop2 hold keeps sync until loop2 locks.
// - Loop1 hold keeps sync until loop1 locks.
// - Source zero blocks pin and lock holds.
// - Source one: pin or lock holds sync directly.
// - Source two: pin or holds trigger pulser.
// - Source three: pulse count write triggers pulser.
// - Reference exclusion leaves reference clocks running.
// - Per-pair exclusion bits keep device clocks running.
// - Reference power-down blocks reference and sync.
`timescale 1ns/10ps
module osc_sync_event_control
(
    input  wire logic                               ref_clk,
    input  wire logic                               resetn,
    input  wire logic [osc_pkg::ADDR_W-1:0]         reg_addr,
    input  wire logic                               reg_wr_en,
    input  wire logic                               reg_rd_en,
    input  wire logic [osc_pkg::DATA_W-1:0]         reg_wdata,
    output logic      [osc_pkg::DATA_W-1:0]         reg_rdata,
    input  wire logic                               sync_pin,
    input  wire logic                               loop1_digital_lock_detect,
    input  wire logic                               loop2_digital_lock_detect,
    input  wire logic                               ref_path_powerdown,
    output logic                                    ref_pulse_path_clear,
    output logic                                    sync_active,
    output logic      [osc_pkg::NUM_DCLK-1:0]       dclk_align_hold,
    output logic                                    ref_align_hold,
    output logic                                    pulser_trigger,
    output logic                                    dyn_delay_start,
    output logic      [osc_pkg::DATA_W-1:0]         dyn_delay_step_count
);

    ////////////////////////////////////////////////////////////////////////////////////
    logic [7:0]                 sync_event_control_reg;
    logic [7:0]                 sync_output_exclusion_mask_reg;
    logic [7:0]                 step_count_reg;
    logic [7:0]                 rdata_reg;
    logic                       sync_meta_reg;
    logic                       sync_sync_reg;
    logic                       pin_prev_reg;
    logic                       source_prev_reg;
    logic [osc_pkg::ONESHOT_W-1:0] oneshot_cnt_reg;
    logic                       active_reg;
    logic [6:0]                 dclk_hold_reg;
    logic                       ref_hold_reg;
    logic                       trigger_reg;
    logic                       dyn_start_reg;

    logic                       edge_trigger_select;
    logic                       align_input_invert;
    logic                       sync_enable;
    logic                       hold_until_loop2_lock;
    logic                       hold_until_loop1_lock;
    osc_pkg::osc_mode_e         event_source;
    logic                       functional;
    logic                       pin_level;
    logic                       pin_rise;
    logic                       pin_term;
    logic                       loop1_hold;
    logic                       loop2_hold;
    logic                       source_assert;
    logic                       source_rise;
    logic                       pulse_cnt_write;
    logic                       active_next;
    logic                       trigger_next;

    assign edge_trigger_select   = sync_event_control_reg[osc_pkg::BIT_EDGE_SEL];
    assign align_input_invert    = sync_event_control_reg[osc_pkg::BIT_INVERT];
    assign sync_enable           = sync_event_control_reg[osc_pkg::BIT_SYNC_EN];
    assign hold_until_loop2_lock = sync_event_control_reg[osc_pkg::BIT_HOLD_LOOP2];
    assign hold_until_loop1_lock = sync_event_control_reg[osc_pkg::BIT_HOLD_LOOP1];
    assign event_source          = osc_pkg::osc_mode_e'(
                                   sync_event_control_reg[osc_pkg::MODE_MSB:osc_pkg::MODE_LSB]);
    assign pulse_cnt_write       = reg_wr_en && (reg_addr == osc_pkg::ADDR_PULSE_CNT);

    ////////////////////////////////////////////////////////////////////////////////////
    // Register file. Writes land one edge after the strobe; reads answer one edge later.
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            sync_event_control_reg         <= osc_pkg::SYNC_CTRL_RST;
            sync_output_exclusion_mask_reg <= osc_pkg::EXCL_MASK_RST;
            step_count_reg                 <= osc_pkg::STEP_CNT_RST;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == osc_pkg::ADDR_SYNC_CTRL)
                sync_event_control_reg <= reg_wdata;
            if (reg_addr == osc_pkg::ADDR_EXCL_MASK)
                sync_output_exclusion_mask_reg <= reg_wdata;
            if (reg_addr == osc_pkg::ADDR_STEP_CNT)
                step_count_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            rdata_reg <= 8'h00;
        else if (reg_rd_en)
        begin
            unique case (reg_addr)
                osc_pkg::ADDR_SYNC_CTRL: rdata_reg <= sync_event_control_reg;
                osc_pkg::ADDR_EXCL_MASK: rdata_reg <= sync_output_exclusion_mask_reg;
                osc_pkg::ADDR_STEP_CNT:  rdata_reg <= step_count_reg;
                default:                 rdata_reg <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Two-flop pin synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            sync_meta_reg <= 1'b0;
            sync_sync_reg <= 1'b0;
        end
        else
        begin
            sync_meta_reg <= sync_pin;
            sync_sync_reg <= sync_meta_reg;
        end
    end

    assign pin_level = sync_sync_reg ^ align_input_invert;
    assign pin_rise  = pin_level && !pin_prev_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pin_prev_reg    <= 1'b0;
            oneshot_cnt_reg <= osc_pkg::ONESHOT_ZERO;
        end
        else
        begin
            pin_prev_reg <= pin_level;
            if (pin_rise && edge_trigger_select)
                oneshot_cnt_reg <= osc_pkg::ONESHOT_LOAD;
            else if (oneshot_cnt_reg != osc_pkg::ONESHOT_ZERO)
                oneshot_cnt_reg <= oneshot_cnt_reg - osc_pkg::ONESHOT_ONE;
        end
    end

    assign pin_term = edge_trigger_select ?
                      (pin_rise || (oneshot_cnt_reg != osc_pkg::ONESHOT_ZERO)) : pin_level;

    assign loop2_hold = hold_until_loop2_lock && !loop2_digital_lock_detect;
    assign loop1_hold = hold_until_loop1_lock && !loop1_digital_lock_detect;

    assign source_assert = pin_term || loop1_hold || loop2_hold;
    assign source_rise   = source_assert && !source_prev_reg;

    assign functional = sync_enable && !ref_path_powerdown;

    ////////////////////////////////////////////////////////////////////////////////////
    // Event source selection. Pulser modes never freeze outputs here; the pulser does it.
    always_comb
    begin
        active_next  = 1'b0;
        trigger_next = 1'b0;
        unique case (event_source)
            osc_pkg::OSC_MODE_OFF:
            begin
                active_next  = 1'b0;
                trigger_next = 1'b0;
            end
            osc_pkg::OSC_MODE_DIRECT:
                active_next = functional && source_assert;
            osc_pkg::OSC_MODE_PULSE_IN:
                trigger_next = functional && source_rise;
            osc_pkg::OSC_MODE_PULSE_SW:
                trigger_next = functional && pulse_cnt_write;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            source_prev_reg <= 1'b0;
            active_reg      <= 1'b0;
            trigger_reg     <= 1'b0;
        end
        else
        begin
            source_prev_reg <= source_assert;
            active_reg      <= active_next;
            trigger_reg     <= trigger_next;
        end
    end

    // Exclusion masks are applied at the same edge so a masked output never glitches.
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            dclk_hold_reg <= 7'h00;
            ref_hold_reg  <= 1'b0;
        end
        else
        begin
            dclk_hold_reg <= {osc_pkg::NUM_DCLK{active_next}}
                             & ~sync_output_exclusion_mask_reg[osc_pkg::NUM_DCLK-1:0];
            ref_hold_reg  <= active_next
                             && !sync_output_exclusion_mask_reg[osc_pkg::BIT_REF_EXCL];
        end
    end

    // Step write honoured only in source three
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            dyn_start_reg <= 1'b0;
        else
            dyn_start_reg <= reg_wr_en && (reg_addr == osc_pkg::ADDR_STEP_CNT)
                             && (event_source == osc_pkg::OSC_MODE_PULSE_SW);
    end

    ////////////////////////////////////////////////////////////////////////////////////
    assign reg_rdata            = rdata_reg;
    assign ref_pulse_path_clear = sync_event_control_reg[osc_pkg::BIT_REF_CLEAR];
    assign sync_active          = active_reg;
    assign dclk_align_hold      = dclk_hold_reg;
    assign ref_align_hold       = ref_hold_reg;
    assign pulser_trigger       = trigger_reg;
    assign dyn_delay_start      = dyn_start_reg;
    assign dyn_delay_step_count = step_count_reg;

    ////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_LEVEL_HOLD:
    assert property ((functional && event_source == osc_pkg::OSC_MODE_DIRECT
                      && !edge_trigger_select && pin_level) |=> sync_active)
        else $error("level sync not held");

    AST_ONESHOT_LEN:
    assert property ((edge_trigger_select && pin_rise) |=> (oneshot_cnt_reg == osc_pkg::ONESHOT_LOAD)
                     ##1 (oneshot_cnt_reg == osc_pkg::ONESHOT_LOAD - osc_pkg::ONESHOT_ONE))
        else $error("one-shot length wrong");

    AST_INVERT:
    assert property (($rose(sync_sync_reg) && align_input_invert && $stable(align_input_invert))
                     |-> $fell(pin_level))
        else $error("inversion not applied");

    AST_DISABLED:
    assert property (!sync_enable |=> (!sync_active && !pulser_trigger))
        else $error("sync active while disabled");

    AST_LOOP2_HOLD:
    assert property ((functional && event_source == osc_pkg::OSC_MODE_DIRECT
                      && hold_until_loop2_lock && !loop2_digital_lock_detect) |=> sync_active)
        else $error("loop2 hold not applied");

    AST_LOOP1_HOLD:
    assert property ((functional && event_source == osc_pkg::OSC_MODE_DIRECT
                      && hold_until_loop1_lock && !loop1_digital_lock_detect) |=> sync_active)
        else $error("loop1 hold not applied");

    AST_MODE_OFF:
    assert property ((event_source == osc_pkg::OSC_MODE_OFF)
                     |=> (!sync_active && !pulser_trigger && !ref_align_hold))
        else $error("event in blocked mode");

    AST_PULSE_PIN:
    assert property ((functional && event_source == osc_pkg::OSC_MODE_PULSE_IN && source_rise)
                     |=> (pulser_trigger && !sync_active))
        else $error("pulser not triggered by pin");

    AST_PULSE_SW:
    assert property ((functional && event_source == osc_pkg::OSC_MODE_PULSE_SW
                      && pulse_cnt_write) |=> pulser_trigger ##1 !pulser_trigger)
        else $error("pulser not triggered by write");

    AST_REF_EXCL:
    assert property (sync_output_exclusion_mask_reg[osc_pkg::BIT_REF_EXCL] |=> !ref_align_hold)
        else $error("excluded reference clocks held");

    AST_DCLK_EXCL:
    assert property (sync_active |-> (dclk_align_hold
                     == ~$past(sync_output_exclusion_mask_reg[6:0])))
        else $error("device clock exclusion wrong");

    AST_POWERDOWN:
    assert property (ref_path_powerdown |=> (!sync_active && !pulser_trigger))
        else $error("event while powered down");

    AST_PIN_SYNC:
    assert property ($rose(sync_pin) |=> ##1 sync_sync_reg)
        else $error("pin synchroniser latency wrong");

endmodule : osc_sync_event_control

// ---- osc_sync_source.sv ----
`timescale 1ns/10ps
module osc_sync_source
#(
    parameter int PIN_DLY_NS = 3
)
(
    input  wire logic pin_req,
    output logic      sync_pin
);
    // The pin moves off the clock grid, so the synchroniser sees a truly asynchronous edge.
    initial
    begin
        sync_pin = 1'b0;
    end

    always @(pin_req)
    begin
        sync_pin <= #(PIN_DLY_NS) pin_req;
    end
endmodule : osc_sync_source

// ---- test_osc_sync_event_control.sv ----
`timescale 1ns/10ps
module test_osc_sync_event_control;
    logic       ref_clk;
    logic       resetn;
    logic [8:0] reg_addr;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       pin_req;
    logic       sync_pin;
    logic       lock1;
    logic       lock2;
    logic       pwrdn;
    logic       clr;
    logic       act;
    logic [6:0] dhold;
    logic       rhold;
    logic       trg;
    logic       dds;
    logic [7:0] step;
    logic [7:0] m;
    logic [7:0] blk [4] = '{8'h01, 8'h10, 8'h11, 8'h1C};
    int         err_count;
    int         check_count;
    int         act_n;
    int         trg_n;
    int         dds_n;
    int         cycles;

    osc_sync_event_control uut
    (
        .ref_clk                   (ref_clk),
        .resetn                    (resetn),
        .reg_addr                  (reg_addr),
        .reg_wr_en                 (reg_wr_en),
        .reg_rd_en                 (reg_rd_en),
        .reg_wdata                 (reg_wdata),
        .reg_rdata                 (reg_rdata),
        .sync_pin                  (sync_pin),
        .loop1_digital_lock_detect (lock1),
        .loop2_digital_lock_detect (lock2),
        .ref_path_powerdown        (pwrdn),
        .ref_pulse_path_clear      (clr),
        .sync_active               (act),
        .dclk_align_hold           (dhold),
        .ref_align_hold            (rhold),
        .pulser_trigger            (trg),
        .dyn_delay_start           (dds),
        .dyn_delay_step_count      (step)
    );

    osc_sync_source #(.PIN_DLY_NS(3)) pin_src
    (
        .pin_req  (pin_req),
        .sync_pin (sync_pin)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sampling at the falling edge keeps the counts clear of clock-edge races.
    always @(negedge ref_clk)
    begin
        act_n += int'(act === 1'b1);
        trg_n += int'(trg === 1'b1);
        dds_n += int'(dds === 1'b1);
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task chk_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task chk_bit(input logic got, input logic exp);
        chk_val({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    task chk_cnt(input int got, input int exp);
        check_count++;
        if (got != exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    task cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task clr_cnt;
        act_n = 0;
        trg_n = 0;
        dds_n = 0;
    endtask : clr_cnt

    task wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask : wr

    task rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        chk_val(reg_rdata, exp);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        resetn = 1'b0;
        reg_addr = 9'h000;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
        pin_req = 1'b0;
        lock1 = 1'b1;
        lock2 = 1'b1;
        pwrdn = 1'b0;
        err_count = 0;
        check_count = 0;
        cycles = 0;
        clr_cnt();
        cyc(6);
        resetn = 1'b1;
        rd_chk(9'h143, 8'h01);
        rd_chk(9'h144, 8'h00);
        rd_chk(9'h142, 8'h00);
        wr(9'h100, 8'hFF);
        rd_chk(9'h100, 8'h00);
        wr(9'h13E, 8'h55);
        rd_chk(9'h13E, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            m = (i == 0) ? 8'h5A : 8'hA5;
            wr(9'h144, m);
            rd_chk(9'h144, m);
            wr(9'h143, 8'h11);
            pin_req = 1'b1;
            // The pin reaches the event logic after two edges, and the third edge registers it.
            cyc(2);
            chk_bit(act, 1'b0);
            cyc(1);
            chk_bit(act, 1'b1);
            chk_val({1'b0, dhold}, {1'b0, ~m[6:0]});
            chk_bit(rhold, ~m[7]);
            cyc(10);
            chk_bit(act, 1'b1);
            pin_req = 1'b0;
            cyc(4);
            chk_bit(act, 1'b0);
        end
        wr(9'h143, 8'h31);
        cyc(4);
        chk_bit(act, 1'b1);
        pin_req = 1'b1;
        cyc(4);
        chk_bit(act, 1'b0);
        pin_req = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            wr(9'h143, blk[i]);
            pwrdn = (i == 2);
            lock1 = (i != 3);
            clr_cnt();
            pin_req = 1'b1;
            cyc(8);
            chk_cnt(act_n, 0);
            pin_req = 1'b0;
            cyc(4);
        end
        pwrdn = 1'b0;
        lock1 = 1'b1;
        wr(9'h143, 8'h51);
        clr_cnt();
        pin_req = 1'b1;
        cyc(20);
        chk_cnt(act_n, 5);
        pin_req = 1'b0;
        cyc(4);
        for (int i = 0; i < 2; i++)
        begin
            wr(9'h143, (i == 0) ? 8'h15 : 8'h19);
            lock1 = (i == 1);
            lock2 = (i == 0);
            cyc(5);
            chk_bit(act, 1'b1);
            lock1 = 1'b1;
            lock2 = 1'b1;
            cyc(5);
            chk_bit(act, 1'b0);
        end
        wr(9'h143, 8'h12);
        clr_cnt();
        pin_req = 1'b1;
        cyc(10);
        pin_req = 1'b0;
        cyc(4);
        chk_cnt(trg_n, 1);
        chk_cnt(act_n, 0);
        // Mode 3 is selected before the step count write so the start pulse is allowed.
        wr(9'h143, 8'h13);
        clr_cnt();
        wr(9'h13E, 8'h03);
        cyc(2);
        chk_cnt(trg_n, 1);
        wr(9'h142, 8'h07);
        cyc(2);
        chk_cnt(dds_n, 1);
        chk_val(step, 8'h07);
        rd_chk(9'h142, 8'h07);
        wr(9'h143, 8'h93);
        cyc(1);
        chk_bit(clr, 1'b1);
        wr(9'h143, 8'h11);
        wr(9'h142, 8'hF0);
        cyc(2);
        chk_cnt(dds_n, 1);
        chk_val(step, 8'hF0);
        chk_bit(clr, 1'b0);
        rd_chk(9'h143, 8'h11);
        print_verdict();
    end
endmodule : test_osc_sync_event_control
